//--- rtl/fsk_pkg.sv
// Shared constants for the FSK modem receive and mode-control block
package fsk_pkg;
  // Clock
  localparam int unsigned CLK_HZ        = 125_000_000;
  // Tone frequencies
  localparam int unsigned LO_SPACE_HZ   = 1070;
  localparam int unsigned LO_MARK_HZ    = 1270;
  localparam int unsigned HI_SPACE_HZ   = 2025;
  localparam int unsigned HI_MARK_HZ    = 2225;
  // Mark/space decision points, midway between the tones of a pair
  localparam int unsigned LO_SPLIT_HZ   = 1170;
  localparam int unsigned HI_SPLIT_HZ   = 2125;
  // Lowest tone still taken as carrier
  localparam int unsigned FLOOR_HZ      = 900;
  // Half periods in clock cycles (longest times, rounded down)
  localparam int unsigned LO_SPACE_HALF = CLK_HZ / (2 * LO_SPACE_HZ);
  localparam int unsigned LO_MARK_HALF  = CLK_HZ / (2 * LO_MARK_HZ);
  localparam int unsigned HI_SPACE_HALF = CLK_HZ / (2 * HI_SPACE_HZ);
  localparam int unsigned HI_MARK_HALF  = CLK_HZ / (2 * HI_MARK_HZ);
  localparam int unsigned LO_SPLIT_HALF = CLK_HZ / (2 * LO_SPLIT_HZ);
  localparam int unsigned HI_SPLIT_HALF = CLK_HZ / (2 * HI_SPLIT_HZ);
  localparam int unsigned FLOOR_HALF    = CLK_HZ / (2 * FLOOR_HZ);
  localparam int          HALF_W        = 17;
  // Good half cycles in a row before the carrier counts as present
  localparam logic [4:0]  CARRIER_HALVES = 5'h10;
  // Register map (byte addresses)
  localparam logic [3:0]  CTRL_ADDR     = 4'h0;
  localparam logic [3:0]  STATUS_ADDR   = 4'h4;
  localparam logic [2:0]  CTRL_RESET    = 3'h0;
  localparam int          CTRL_READY    = 0;
  localparam int          CTRL_TXDATA   = 1;
  localparam int          CTRL_HANGUP   = 2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {IDLE, HANDSHAKE, ONLINE} link_state_t;
endpackage

//--- rtl/tone_if.sv
// Carrier between controller and modulator tone synthesiser
`timescale 1ns/100ps
interface tone_if;
  logic upper;
  logic mark;
  logic tone;
  modport synth (input upper, input mark, output tone);
  modport ctrl  (output upper, output mark, input tone);
endinterface

//--- rtl/tone_synth.sv
// Square-wave FSK tone synthesiser for the modulator
`timescale 1ns/100ps
module tone_synth import fsk_pkg::*; #(
  parameter logic [HALF_W-1:0] LO_SPACE = HALF_W'(LO_SPACE_HALF),
  parameter logic [HALF_W-1:0] LO_MARK  = HALF_W'(LO_MARK_HALF),
  parameter logic [HALF_W-1:0] HI_SPACE = HALF_W'(HI_SPACE_HALF),
  parameter logic [HALF_W-1:0] HI_MARK  = HALF_W'(HI_MARK_HALF)
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Controller side
  tone_if.synth     tif
);
  logic [HALF_W-1:0] count;
  logic              tone;
  wire  [HALF_W-1:0] half_len;
  wire               wrap;

  // Mark is the higher tone of the selected pair
  assign half_len = tif.upper ? (tif.mark ? HI_MARK : HI_SPACE)
                              : (tif.mark ? LO_MARK : LO_SPACE);
  assign wrap     = (count >= half_len - HALF_W'(1));
  assign tif.tone = tone;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tone  <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + HALF_W'(1);
      if (wrap) begin
        tone <= ~tone;
      end
    end
  end
endmodule // tone_synth

//--- rtl/fsk_modem_ctrl.sv
// FSK modem demodulator, mode control, supervisor and register slave
//
// Behaviour
// - Each received half cycle is judged mark or space, mark giving 1 and space 0.
// - With mode low the demodulator takes the lower pair, 1070 and 1270 Hz.
// - With mode high the demodulator takes the upper pair, 2025 and 2225 Hz.
// - A low test input retunes the demodulator to the pair the modulator sends.
// - Entering self test keeps all link state; only mode changes.
// - Mode is high for hook low and ring high, low for the reverse, inverted in test.
// - A supervisor sequences the handshake and disconnect and drives line pickup.
// - The modulator sends mark on the higher tone of its pair, space on the lower.
`timescale 1ns/100ps
module fsk_modem_ctrl import fsk_pkg::*; #(
  parameter logic [HALF_W-1:0] LO_SPLIT = HALF_W'(LO_SPLIT_HALF),
  parameter logic [HALF_W-1:0] HI_SPLIT = HALF_W'(HI_SPLIT_HALF),
  parameter logic [HALF_W-1:0] FLOOR    = HALF_W'(FLOOR_HALF),
  parameter logic [HALF_W-1:0] LO_SPACE = HALF_W'(LO_SPACE_HALF),
  parameter logic [HALF_W-1:0] LO_MARK  = HALF_W'(LO_MARK_HALF),
  parameter logic [HALF_W-1:0] HI_SPACE = HALF_W'(HI_SPACE_HALF),
  parameter logic [HALF_W-1:0] HI_MARK  = HALF_W'(HI_MARK_HALF)
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Line and coupler
  input  wire logic        rx_carrier_in,
  input  wire logic        hook_switch_in,
  input  wire logic        ringing_detect_in,
  input  wire logic        loopback_test_in,
  output logic             pickup_line_out,
  output logic             tx_carrier_out,
  // Terminal and filters
  output logic             rx_data_out,
  output logic             mode_out,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  // Mode control
  logic        base_mode;
  wire         next_mode;
  // Other hook/ring combinations keep the last decoded mode
  wire         set_hi = !hook_switch_in && ringing_detect_in;
  wire         set_lo = hook_switch_in && !ringing_detect_in;
  wire         next_base = set_hi ? 1'b1 : (set_lo ? 1'b0 : base_mode);
  assign next_mode = next_base ^ !loopback_test_in;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      base_mode <= 1'b0;
      mode_out  <= 1'b0;
    end else begin
      base_mode <= next_base;
      mode_out  <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-cycle demodulator
  logic              rx_prev;
  logic [HALF_W-1:0] half_cnt;
  logic [4:0]        good_run;
  logic              carrier_ok;
  logic              rx_bit;
  wire               edge_seen = rx_carrier_in ^ rx_prev;
  // Pair follows mode, so self test lands on the sent pair
  wire [HALF_W-1:0]  split = mode_out ? HI_SPLIT : LO_SPLIT;
  wire               too_long = (half_cnt >= FLOOR);
  wire               half_mark = (half_cnt < split);
  wire               run_full = (good_run == CARRIER_HALVES);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev  <= 1'b0;
      half_cnt <= '0;
      good_run <= '0;
      rx_bit   <= 1'b1;
    end else begin
      rx_prev <= rx_carrier_in;
      if (edge_seen) begin
        half_cnt <= '0;
        rx_bit   <= half_mark;
        // An edge that ends an over-long half does not count as good
        if (too_long) begin
          good_run <= '0;
        end else if (!run_full) begin
          good_run <= good_run + 5'h1;
        end
      end else if (too_long) begin
        good_run <= '0;
      end else begin
        half_cnt <= half_cnt + HALF_W'(1);
      end
    end
  end
  assign carrier_ok = run_full;

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor
  link_state_t state;
  link_state_t next_state;
  logic [2:0]  ctrl;
  wire         term_ready = ctrl[CTRL_READY];
  wire         hang_up = ctrl[CTRL_HANGUP] || !term_ready;

  // Self test touches neither state nor carrier history
  always_comb begin
    next_state = state;
    unique case (state)
      IDLE: begin
        if (term_ready && (ringing_detect_in || !hook_switch_in)) begin
          next_state = HANDSHAKE;
        end
      end
      HANDSHAKE: begin
        if (hang_up) begin
          next_state = IDLE;
        end else if (carrier_ok) begin
          next_state = ONLINE;
        end
      end
      ONLINE: begin
        if (hang_up || !carrier_ok) begin
          next_state = IDLE;
        end
      end
    endcase
  end

  wire link_up = (state == ONLINE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state           <= IDLE;
      pickup_line_out <= 1'b0;
      rx_data_out     <= 1'b1;
    end else begin
      state           <= next_state;
      pickup_line_out <= (next_state != IDLE);
      rx_data_out     <= (link_up && carrier_ok) ? rx_bit : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator: sends the pair opposite the one normally received
  tone_if tif ();
  assign tif.upper = !base_mode;
  assign tif.mark  = ctrl[CTRL_TXDATA] || !link_up;

  tone_synth #(
    .LO_SPACE (LO_SPACE),
    .LO_MARK  (LO_MARK),
    .HI_SPACE (HI_SPACE),
    .HI_MARK  (HI_MARK)
  ) u_tone (
    .clock (clock),
    .rst_n (rst_n),
    .tif   (tif)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_carrier_out <= 1'b0;
    end else begin
      tx_carrier_out <= tif.tone && (state != IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic       w_lane0;
  wire        aw_take = s_axi_awvalid && s_axi_awready;
  wire        w_take = s_axi_wvalid && s_axi_wready;
  wire        do_write = aw_held && w_held && !s_axi_bvalid;
  wire        wr_ctrl = (aw_addr == CTRL_ADDR);
  wire        wr_hit = wr_ctrl || (aw_addr == STATUS_ADDR);
  wire        ar_take = s_axi_arvalid && s_axi_arready;
  wire        rd_ctrl = (s_axi_araddr == CTRL_ADDR);
  wire        rd_stat = (s_axi_araddr == STATUS_ADDR);
  wire [31:0] stat_word = {26'h0, rx_bit, state, link_up, carrier_ok,
                           mode_out};
  wire [31:0] rd_word = rd_ctrl ? {29'h0, ctrl} :
                        (rd_stat ? stat_word : 32'h0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      ctrl          <= CTRL_RESET;
    end else begin
      if (aw_take) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (wr_ctrl && w_lane0) begin
          ctrl <= w_data[2:0];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // fsk_modem_ctrl

//--- dv/line_model.sv
// Line model: limited square-wave carrier at a settable half period
`timescale 1ns/100ps
module line_model import fsk_pkg::*; (
  // Clock
  input  wire logic              clock,
  // Half period in cycles, zero for silence
  input  wire logic [HALF_W-1:0] half,
  // Limiter output
  output logic                   carrier
);
  int count = 0;
  initial carrier = 1'b0;
  // Equal halves keep the duty cycle at one half
  always @(posedge clock) begin
    if (half == 17'h0) begin
      count <= 0;
    end else if (count + 1 >= half) begin
      count   <= 0;
      carrier <= ~carrier;
    end else begin
      count <= count + 1;
    end
  end
endmodule // line_model

//--- dv/fsk_modem_ctrl_monitor.sv
// Port-level checks on the modem receive and mode-control block
`timescale 1ns/100ps
module fsk_modem_ctrl_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Coupler and terminal
  input wire logic hook_switch_in,
  input wire logic ringing_detect_in,
  input wire logic loopback_test_in,
  input wire logic pickup_line_out,
  input wire logic tx_carrier_out,
  input wire logic rx_data_out,
  input wire logic mode_out,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire orig_req = !hook_switch_in && ringing_detect_in;
  wire ans_req  = hook_switch_in && !ringing_detect_in;
  wire both_in  = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                  && s_axi_wready;
  ////////////////////////////////////////////////////////////////////////////
  chk_mode_orig: assert property (
    (orig_req && loopback_test_in)[*3] |-> mode_out)
    else $error("mode not high for hook low, ring high");
  chk_mode_ans: assert property (
    (ans_req && loopback_test_in)[*3] |-> !mode_out)
    else $error("mode not low for hook high, ring low");
  chk_test_orig: assert property (
    (orig_req && !loopback_test_in)[*3] |-> !mode_out)
    else $error("self test did not invert mode");
  chk_test_ans: assert property (
    (ans_req && !loopback_test_in)[*3] |-> mode_out)
    else $error("self test did not invert mode");
  // Data stays at mark while no link exists
  chk_rx_clamp: assert property (
    (!pickup_line_out)[*2] |-> rx_data_out)
    else $error("received data left mark while idle");
  chk_tx_quiet: assert property (
    (!pickup_line_out)[*3] |-> !tx_carrier_out)
    else $error("carrier sent while idle");
  chk_write_resp: assert property (
    both_in |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after accept");
  chk_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after accept");
  ////////////////////////////////////////////////////////////////////////////
  cover property (pickup_line_out && !rx_data_out);
  cover property (pickup_line_out && !loopback_test_in && rx_data_out);
  cover property ($fell(pickup_line_out));
endmodule // fsk_modem_ctrl_monitor

bind fsk_modem_ctrl fsk_modem_ctrl_monitor mon (
  .clock, .rst_n, .hook_switch_in, .ringing_detect_in, .loopback_test_in,
  .pickup_line_out, .tx_carrier_out, .rx_data_out, .mode_out,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

//--- dv/fsk_modem_ctrl_tb.sv
// Self-checking bench for the modem receive and mode-control block
`timescale 1ns/100ps
module fsk_modem_ctrl_tb import fsk_pkg::*; ();
  // Short half periods keep each carrier acquisition brief
  localparam logic [16:0] LS = 17'h46, LM = 17'h32, HS = 17'h2c, HM = 17'h24;
  logic        clock = 1'b0, rst_n = 1'b0;
  logic        hook_switch_in = 1'b1, ringing_detect_in = 1'b0;
  logic        loopback_test_in = 1'b1, rx_carrier_in;
  logic        pickup_line_out, tx_carrier_out, rx_data_out, mode_out;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [16:0] half = 17'h0;
  logic [3:0]  mode_rows [4] = '{4'hb, 4'hc, 4'h2, 4'h5};
  int          n_fail = 0, n_compared = 0, cycles = 0;

  line_model line (.clock, .half, .carrier(rx_carrier_in));
  fsk_modem_ctrl #(
    .LO_SPLIT(17'h3c), .HI_SPLIT(17'h28), .FLOOR(17'h64), .LO_SPACE(LS),
    .LO_MARK(LM), .HI_SPACE(HS), .HI_MARK(HM)
  ) uut (
    .clock, .rst_n, .rx_carrier_in, .hook_switch_in, .ringing_detect_in,
    .loopback_test_in, .pickup_line_out, .tx_carrier_out, .rx_data_out,
    .mode_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  ////////////////////////////////////////////////////////////////////////////
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Bounded wait; the compare that follows judges the outcome
  task automatic wait_rx(input logic v, input logic [16:0] h);
    int n;
    n = 0;
    half <= h;
    while (rx_data_out !== v && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check(rx_data_out, v);
  endtask
  // Aligns to one tone edge, then counts cycles to the next
  task automatic tx_half(input logic [16:0] exp);
    logic last;
    int   n;
    last = tx_carrier_out;
    n = 0;
    while (tx_carrier_out === last && n < 3000) begin
      @(posedge clock);
      n++;
    end
    last = tx_carrier_out;
    n = 0;
    while (tx_carrier_out === last && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check(n, 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check(rx_data_out, 1'b1);
    check({pickup_line_out, tx_carrier_out, mode_out}, 3'h0);
    wr(4'hc, 32'h1);
    check(rs, RESP_SLVERR);
    rdr(CTRL_ADDR);
    check(rd, 32'h0);
    rdr(4'h8);
    check(rs, RESP_SLVERR);
    foreach (mode_rows[i]) begin
      loopback_test_in  <= mode_rows[i][3];
      hook_switch_in    <= mode_rows[i][2];
      ringing_detect_in <= mode_rows[i][1];
      repeat (4) @(posedge clock);
      check(mode_out, mode_rows[i][0]);
      rdr(STATUS_ADDR);
      check(rd[0], mode_rows[i][0]);
    end
    // Ring with hook low starts the handshake on the upper pair
    loopback_test_in  <= 1'b1;
    hook_switch_in    <= 1'b0;
    ringing_detect_in <= 1'b1;
    wr(CTRL_ADDR, 32'h1);
    check(rs, RESP_OKAY);
    rdr(CTRL_ADDR);
    check(rd, 32'h1);
    repeat (3) @(posedge clock);
    check({pickup_line_out, rx_data_out}, 2'h3);
    wait_rx(1'b0, HS);
    wait_rx(1'b1, HM);
    rdr(STATUS_ADDR);
    check(rd[5:0], 6'h37);
    // Originate sends the lower pair; transmit bit low gives space
    tx_half(LS);
    // Self test: lower split, a half of 50 reads mark only there
    loopback_test_in <= 1'b0;
    wait_rx(1'b0, LS);
    wait_rx(1'b1, LM);
    check({pickup_line_out, mode_out}, 2'h2);
    rdr(STATUS_ADDR);
    check(rd[5:0], 6'h36);
    wr(CTRL_ADDR, 32'h3);
    tx_half(LM);
    wr(CTRL_ADDR, 32'h4);
    repeat (4) @(posedge clock);
    check({pickup_line_out, rx_data_out}, 2'h1);
    rdr(STATUS_ADDR);
    check(rd[4:3], 2'h0);
    results;
  end
endmodule // fsk_modem_ctrl_tb
